// ---- verilog/fsiw_top.sv ----
`timescale 1ns/1ps
module fsiw_top #(
    parameter int WD_TICK_CYCLES = fsiw_pkg::WD_TICK_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register read port from the slave controller
    input wire logic reg_rd_en,
    input wire logic [15:0] reg_addr,
    output logic [15:0] reg_rd_data,
    output logic reg_rd_valid,
    // Register write port, alias and identifier refuse writes
    input wire logic reg_wr_en,
    output logic reg_wr_refused,
    // Alias sources
    input wire logic eeprom_alias_valid,
    input wire logic [15:0] eeprom_alias,
    input wire logic [15:0] panel_alias,
    input wire logic alias_from_panel,
    output logic [15:0] alias_monitor,
    // Device identifier
    input wire logic [15:0] stored_panel_device_identifier,
    input wire logic ident_request,
    output logic [15:0] al_status_code,
    // Watchdog
    input wire logic wd_time_wr,
    input wire logic [15:0] wd_time_value,
    input wire logic pd_exchange_ok,
    input wire logic fault_clear,
    output logic fieldbus_timeout_fault,
    // Mode selection
    input wire logic keypad_mode_wr,
    input wire logic keypad_mode,
    input wire logic coe_mode_wr,
    input wire logic [7:0] coe_mode_value,
    input wire logic pdo_assign_wr,
    input wire logic rx_1600_assigned,
    input wire logic tx_1a00_assigned,
    input wire logic bypass_objects_mapped,
    output logic mode_monitor,
    output logic mode_refused,
    // Identification
    input wire logic product_wr,
    input wire logic [31:0] product_value,
    input wire logic revision_wr,
    input wire logic [15:0] revision_value,
    output logic [31:0] vendor_code,
    output logic [31:0] product_code,
    output logic [15:0] revision_number
);
    // ********************
    // Start-up sequence
    // ********************
    // Every output has a flop of its own below
    fsiw_pkg::fsiw_state_e state_ff;
    fsiw_pkg::fsiw_state_e nxt_state;
    logic [15:0] station_alias_value_ff;
    logic [15:0] explicit_identifier_value_ff;
    logic [15:0] reg_rd_data_ff;
    logic reg_rd_valid_ff;
    logic reg_wr_refused_ff;
    logic [15:0] al_status_code_ff;
    logic [15:0] wd_time_ff;
    logic fault_ff;
    logic wd_expired;
    logic mode_ff;
    logic mode_refused_ff;
    logic pdo402_ff;
    logic bypass_only;
    logic [31:0] vendor_ff;
    logic [31:0] product_ff;
    logic [15:0] revision_ff;

    // Boot, one load cycle, then run
    // Sources settle during boot before they are sampled
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            fsiw_pkg::ST_BOOT: nxt_state = fsiw_pkg::ST_LOAD;
            fsiw_pkg::ST_LOAD: nxt_state = fsiw_pkg::ST_RUN;
            fsiw_pkg::ST_RUN: nxt_state = fsiw_pkg::ST_RUN;
            default: nxt_state = fsiw_pkg::ST_BOOT;
        endcase
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= fsiw_pkg::ST_BOOT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ********************
    // Station alias
    // ********************
    // Sampled only in the load state, so sources are caught after reset release
    // Panel source wins; with no valid source the reset value stays
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            station_alias_value_ff <= fsiw_pkg::ALIAS_RESET;
        end else if (state_ff == fsiw_pkg::ST_LOAD) begin
            if (alias_from_panel) begin
                station_alias_value_ff <= panel_alias;
            end else if (eeprom_alias_valid) begin
                station_alias_value_ff <= eeprom_alias;
            end
        end
    end

    // Monitor copy of the alias in use
    // One cycle behind the register, harmless for a display value
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            alias_monitor <= fsiw_pkg::ALIAS_RESET;
        end else begin
            alias_monitor <= station_alias_value_ff;
        end
    end

    // ********************
    // Device identifier
    // ********************
    // Reloaded from the non-volatile copy on each start-up
    // Later changes of the stored copy wait for the next start-up
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            explicit_identifier_value_ff <= fsiw_pkg::IDENT_RESET;
        end else if (state_ff == fsiw_pkg::ST_LOAD) begin
            explicit_identifier_value_ff <= stored_panel_device_identifier;
        end
    end

    // Status code receives identifier on master request
    // Requests before run are ignored, the identifier is not loaded yet
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            al_status_code_ff <= fsiw_pkg::STATUS_RESET;
        end else if (ident_request && state_ff == fsiw_pkg::ST_RUN) begin
            al_status_code_ff <= explicit_identifier_value_ff;
        end
    end

    // ********************
    // Register access
    // ********************
    // Read answer one cycle after the strobe, unmapped reads return zero
    // Fixed latency, no wait states, so the master needs no ready signal
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rd_data_ff <= fsiw_pkg::UNMAPPED_READ;
            reg_rd_valid_ff <= 1'b0;
        end else begin
            reg_rd_valid_ff <= reg_rd_en;
            if (reg_rd_en) begin
                case (reg_addr)
                    fsiw_pkg::ALIAS_OFFSET: begin
                        reg_rd_data_ff <= station_alias_value_ff;
                    end
                    fsiw_pkg::IDENT_OFFSET: begin
                        reg_rd_data_ff <= explicit_identifier_value_ff;
                    end
                    default: reg_rd_data_ff <= fsiw_pkg::UNMAPPED_READ;
                endcase
            end
        end
    end

    // Writes to the two read-only words are flagged and dropped
    // Nothing is stored, so these words cannot change during operation
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_wr_refused_ff <= 1'b0;
        end else begin
            reg_wr_refused_ff <= reg_wr_en && ((reg_addr == fsiw_pkg::ALIAS_OFFSET) ||
                (reg_addr == fsiw_pkg::IDENT_OFFSET));
        end
    end

    // ********************
    // Watchdog
    // ********************
    // Time comes from the master, zero leaves the watchdog off
    // A new time takes effect at once, the running count is kept
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wd_time_ff <= fsiw_pkg::WD_TIME_RESET;
        end else if (wd_time_wr) begin
            wd_time_ff <= wd_time_value;
        end
    end

    // Divider and elapsed counter live in the helper module
    fsiw_watchdog #(
        .TICK_CYCLES(WD_TICK_CYCLES)
    ) u_watchdog (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wd_time(wd_time_ff),
        .restart(pd_exchange_ok),
        .expired(wd_expired)
    );

    // Sticky fault; a new expiry wins over a clear in the same cycle
    // Restart alone never clears it, only the fault logic does
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fault_ff <= 1'b0;
        end else if (wd_expired) begin
            fault_ff <= 1'b1;
        end else if (fault_clear) begin
            fault_ff <= 1'b0;
        end
    end

    // ********************
    // Operation mode
    // ********************
    // Profile objects are assigned unless the master says otherwise
    // Only a new assignment event changes this state
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pdo402_ff <= 1'b1;
        end else if (pdo_assign_wr) begin
            pdo402_ff <= rx_1600_assigned && tx_1a00_assigned;
        end
    end

    // Profile requests are refused while only bypass objects are mapped
    assign bypass_only = !pdo402_ff && bypass_objects_mapped;

    // Last writer wins; assignment event has priority over same-cycle writes
    // A refused request leaves the mode as it was
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mode_ff <= fsiw_pkg::MODE_PROFILE;
            mode_refused_ff <= 1'b0;
        end else begin
            mode_refused_ff <= 1'b0;
            if (pdo_assign_wr) begin
                if (rx_1600_assigned && tx_1a00_assigned) begin
                    mode_ff <= fsiw_pkg::MODE_PROFILE;
                end else if (bypass_objects_mapped) begin
                    mode_ff <= fsiw_pkg::MODE_BYPASS;
                end
            end else if (coe_mode_wr) begin
                // Velocity code picks the profile, any other code the bypass
                if (coe_mode_value != fsiw_pkg::COE_MODE_VELOCITY) begin
                    mode_ff <= fsiw_pkg::MODE_BYPASS;
                end else if (bypass_only) begin
                    mode_refused_ff <= 1'b1;
                end else begin
                    mode_ff <= fsiw_pkg::MODE_PROFILE;
                end
            end else if (keypad_mode_wr) begin
                // Same refusal as the object write
                if (keypad_mode == fsiw_pkg::MODE_BYPASS) begin
                    mode_ff <= fsiw_pkg::MODE_BYPASS;
                end else if (bypass_only) begin
                    mode_refused_ff <= 1'b1;
                end else begin
                    mode_ff <= fsiw_pkg::MODE_PROFILE;
                end
            end
        end
    end

    // ********************
    // Identity words
    // ********************
    // Vendor stays fixed; product and revision may be overwritten
    // Vendor reloaded every cycle so nothing can overwrite it
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            vendor_ff <= fsiw_pkg::VENDOR_CODE;
            product_ff <= fsiw_pkg::PRODUCT_DEFAULT;
            revision_ff <= fsiw_pkg::REVISION_DEFAULT;
        end else begin
            vendor_ff <= fsiw_pkg::VENDOR_CODE;
            if (product_wr) begin
                product_ff <= product_value;
            end
            if (revision_wr) begin
                revision_ff <= revision_value;
            end
        end
    end

    // ********************
    // Outputs
    // ********************
    // Plain copies of flops, no logic in between
    assign reg_rd_data = reg_rd_data_ff;
    assign reg_rd_valid = reg_rd_valid_ff;
    assign reg_wr_refused = reg_wr_refused_ff;
    assign al_status_code = al_status_code_ff;
    assign fieldbus_timeout_fault = fault_ff;
    assign mode_monitor = mode_ff;
    assign mode_refused = mode_refused_ff;
    assign vendor_code = vendor_ff;
    assign product_code = product_ff;
    assign revision_number = revision_ff;
endmodule

// ---- verilog/fsiw_pkg.sv ----
// Behaviour
// - Alias placed at offset 0x0012 at start-up
// - Stored EEPROM alias loaded at start-up
// - Panel alias copied in as alternative source
// - Alias in use shown on monitor output
// - Panel identifier reloaded from storage each start-up
// - Offset 0x0134 returns the panel identifier
// - Identifier loaded into status code on request
// - Watchdog restarted by each good exchange
// - Watchdog expiry raises fieldbus timeout fault
// - Zero watchdog time never raises the fault
// - Start in velocity profile unless selected otherwise
// - Latest selection wins, shown on mode monitor
// - Keypad parameter selects operation mode
// - Modes-of-operation write changes the mode
// - Object assignment selects profile or bypass
// - Profile refused when only bypass objects mapped
// - Fixed vendor code, modifiable product and revision
package fsiw_pkg;
    // ********************
    // Register map
    // ********************
    localparam logic [15:0] ALIAS_OFFSET = 16'h0012;
    localparam logic [15:0] IDENT_OFFSET = 16'h0134;
    localparam logic [15:0] UNMAPPED_READ = 16'h0000;

    // ********************
    // Reset and default values
    // ********************
    localparam logic [15:0] ALIAS_RESET = 16'h0000;
    localparam logic [15:0] IDENT_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [31:0] VENDOR_CODE = 32'h0000_0a5a; // Arbitrary value
    localparam logic [31:0] PRODUCT_DEFAULT = 32'h0000_0001; // Arbitrary value
    localparam logic [15:0] REVISION_DEFAULT = 16'h0001;
    localparam logic [15:0] WD_TIME_RESET = 16'h0000;

    // ********************
    // Mode encodings
    // ********************
    localparam logic [7:0] COE_MODE_VELOCITY = 8'h02;
    typedef enum logic [0:0] {
        MODE_PROFILE = 1'b0,
        MODE_BYPASS = 1'b1
    } fsiw_mode_e;
    typedef enum logic [1:0] {
        ST_BOOT = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } fsiw_state_e;

    // ********************
    // Timing
    // ********************
    localparam int CLK_HZ = 40_000_000;
    localparam int WD_TICK_US = 1000;
    localparam int WD_TICK_CYCLES = (CLK_HZ / 1_000_000) * WD_TICK_US;
endpackage

// ---- verilog/fsiw_watchdog.sv ----
`timescale 1ns/1ps
module fsiw_watchdog #(
    parameter int TICK_CYCLES = fsiw_pkg::WD_TICK_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Control
    input wire logic [15:0] wd_time,
    input wire logic restart,
    // Result
    output logic expired
);
    // ********************
    // Millisecond divider
    // ********************
    logic [31:0] div_ff;
    logic tick_ff;
    logic [15:0] elapsed_ff;
    logic expired_ff;

    // Enable pulse, one per tick period, divider restarted by each good exchange
    always_ff @(posedge core_clk) begin
        if (sys_rst || restart) begin
            div_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (div_ff == 32'(TICK_CYCLES - 1)) begin
            div_ff <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    // ********************
    // Elapsed time
    // ********************
    // Restart beats the tick so a good exchange is never missed
    always_ff @(posedge core_clk) begin
        if (sys_rst || restart) begin
            elapsed_ff <= 16'h0000;
        end else if (tick_ff && elapsed_ff != 16'hffff) begin
            elapsed_ff <= elapsed_ff + 16'h0001;
        end
    end

    // Zero time means no watchdog at all
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            expired_ff <= 1'b0;
        end else begin
            expired_ff <= (wd_time != 16'h0000) && (elapsed_ff >= wd_time);
        end
    end

    assign expired = expired_ff;
endmodule

// ---- bench/fsiw_master_model.sv ----
`timescale 1ns/1ps
module fsiw_master_model (
    // Clock
    input wire logic core_clk,
    // Answers
    input wire logic reg_rd_valid,
    input wire logic reg_wr_refused,
    input wire logic [15:0] reg_rd_data,
    // Register requests
    output logic reg_rd_en,
    output logic reg_wr_en,
    output logic [15:0] reg_addr,
    // Watchdog requests
    output logic wd_time_wr,
    output logic [15:0] wd_time_value,
    output logic pd_exchange_ok
);
    // Idle bus
    initial begin
        {reg_rd_en, reg_wr_en, wd_time_wr, pd_exchange_ok} = 4'h0;
        {reg_addr, wd_time_value} = 32'hfffe_0000;
    end
    // Ring slot address, counting down
    function automatic logic [15:0] ring_addr(input logic [15:0] slot);
        return 16'h0000 - slot;
    endfunction
    // Failed unit marks working counters invalid
    function automatic logic wc_state(input logic unit_failed);
        return unit_failed;
    endfunction
    // Taken at one edge, answered the next cycle
    task automatic access(input logic wr, input logic [15:0] addr,
        output logic [15:0] data, output logic ack);
        @(negedge core_clk);
        {reg_rd_en, reg_wr_en} = {!wr, wr};
        reg_addr = addr;
        @(negedge core_clk);
        {reg_rd_en, reg_wr_en} = 2'b00;
        reg_addr = ~addr; // No stale address left on the bus
        ack = wr ? reg_wr_refused : reg_rd_valid;
        data = reg_rd_data;
    endtask
    // Watchdog time write or good exchange
    task automatic pulse(input logic wd, input logic [15:0] ticks);
        @(negedge core_clk);
        {wd_time_wr, pd_exchange_ok} = {wd, !wd};
        wd_time_value = ticks;
        @(negedge core_clk);
        {wd_time_wr, pd_exchange_ok} = 2'b00;
    endtask
endmodule

// ---- bench/fsiw_monitor.sv ----
`timescale 1ns/1ps
module fsiw_monitor (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic reg_rd_en,
    input wire logic reg_wr_en,
    input wire logic reg_rd_valid,
    input wire logic reg_wr_refused,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_rd_data,
    // Identifier
    input wire logic [15:0] stored_panel_device_identifier,
    input wire logic ident_request,
    input wire logic [15:0] al_status_code,
    // Watchdog
    input wire logic wd_time_wr,
    input wire logic [15:0] wd_time_value,
    input wire logic fault_clear,
    input wire logic fieldbus_timeout_fault,
    // Mode
    input wire logic coe_mode_wr,
    input wire logic [7:0] coe_mode_value,
    input wire logic pdo_assign_wr,
    input wire logic mode_monitor,
    input wire logic mode_refused,
    // Identity
    input wire logic product_wr,
    input wire logic [31:0] product_value,
    input wire logic [31:0] product_code
);
    logic [2:0] run_cnt_ff;
    logic wd_off_ff;
    logic hit;
    // Edges since release; requests count only when running
    always_ff @(posedge core_clk) begin
        if (sys_rst) run_cnt_ff <= 3'h0;
        else if (run_cnt_ff != 3'h4) run_cnt_ff <= run_cnt_ff + 3'h1;
    end
    // Zero time means no supervision
    always_ff @(posedge core_clk) begin
        if (sys_rst) wd_off_ff <= 1'b1;
        else if (wd_time_wr) wd_off_ff <= (wd_time_value == 16'h0000);
    end
    // Address names a read-only register
    assign hit = reg_addr == fsiw_pkg::ALIAS_OFFSET || reg_addr == fsiw_pkg::IDENT_OFFSET;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_rd; reg_rd_en |=> reg_rd_valid; endproperty
    a_rd: assert property (p_rd) else $error("read unanswered");
    property p_id; reg_rd_en && reg_addr == fsiw_pkg::IDENT_OFFSET && run_cnt_ff == 3'h4
        |=> reg_rd_data == $past(stored_panel_device_identifier); endproperty
    a_id: assert property (p_id) else $error("bad identifier");
    property p_unm; reg_rd_en && !hit |=> reg_rd_data == fsiw_pkg::UNMAPPED_READ; endproperty
    a_unm: assert property (p_unm) else $error("unmapped data");
    property p_wr; reg_wr_en && hit |=> reg_wr_refused; endproperty
    a_wr: assert property (p_wr) else $error("write taken");
    property p_st; ident_request && run_cnt_ff == 3'h4
        |=> al_status_code == $past(stored_panel_device_identifier); endproperty
    a_st: assert property (p_st) else $error("status code");
    property p_lat; fieldbus_timeout_fault && !fault_clear |=> fieldbus_timeout_fault; endproperty
    a_lat: assert property (p_lat) else $error("fault dropped");
    property p_off; wd_off_ff && $past(wd_off_ff) |-> !$rose(fieldbus_timeout_fault); endproperty
    a_off: assert property (p_off) else $error("fault, no time");
    property p_ref; mode_refused |-> mode_monitor == $past(mode_monitor); endproperty
    a_ref: assert property (p_ref) else $error("refused, changed");
    property p_coe; coe_mode_wr && !pdo_assign_wr && coe_mode_value != 8'h02
        |=> mode_monitor == fsiw_pkg::MODE_BYPASS; endproperty
    a_coe: assert property (p_coe) else $error("coe mode");
    property p_prd; product_wr |=> product_code == $past(product_value); endproperty
    a_prd: assert property (p_prd) else $error("product");
endmodule
bind fsiw_top fsiw_monitor u_mon (.*);

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
    logic core_clk = 1'b0, sys_rst, alias_from_panel, ident_request = 1'b0;
    logic eeprom_alias_valid = 1'b1, fault_clear = 1'b0, keypad_mode_wr = 1'b0;
    logic keypad_mode = 1'b0, coe_mode_wr = 1'b0, pdo_assign_wr = 1'b0, product_wr = 1'b0;
    logic rx_1600_assigned = 1'b1, tx_1a00_assigned = 1'b1, bypass_objects_mapped = 1'b1;
    logic revision_wr = 1'b0, ack;
    logic [15:0] eeprom_alias = 16'h1234, panel_alias = 16'h00c5, revision_value = 16'h0007;
    logic [15:0] stored_panel_device_identifier, rd_data;
    logic [7:0] coe_mode_value = 8'h00;
    logic [31:0] product_value = 32'h0000_4d21;
    logic reg_rd_en, reg_wr_en, reg_rd_valid, reg_wr_refused, wd_time_wr, pd_exchange_ok;
    logic fieldbus_timeout_fault, mode_monitor, mode_refused;
    logic [15:0] reg_addr, reg_rd_data, wd_time_value, alias_monitor, al_status_code;
    logic [15:0] revision_number;
    logic [31:0] vendor_code, product_code;
    int n_errors = 0;
    int n_compared = 0;
    int waited;
    always #12.5 core_clk = ~core_clk;
    fsiw_top #(.WD_TICK_CYCLES(4)) u_dut (.*);
    fsiw_master_model u_mst (.*);
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s: %h not %h", $time, what, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Access; writes expect the refusal flag
    task automatic acc(input logic wr, input logic [15:0] addr, input logic [15:0] exp);
        u_mst.access(wr, addr, rd_data, ack);
        chk(ack, wr ? exp : 16'h0001, "answer");
        if (!wr) chk(rd_data, exp, "read");
    endtask
    // Reset with a chosen alias source and identifier
    task automatic boot(input logic panel, input logic [15:0] ident);
        sys_rst = 1'b1;
        {alias_from_panel, stored_panel_device_identifier} = {panel, ident};
        step(16);
        sys_rst = 1'b0;
        step(4);
    endtask
    // Mode request bits: keypad write, keypad value, coe write, pdo assign
    task automatic mode_req(input logic [3:0] req, input logic [7:0] cv, input logic m, r);
        step(1);
        {keypad_mode_wr, keypad_mode, coe_mode_wr, pdo_assign_wr} = req;
        coe_mode_value = cv;
        step(1);
        {keypad_mode_wr, coe_mode_wr, pdo_assign_wr} = 3'h0;
        chk(mode_monitor, m, "mode");
        chk(mode_refused, r, "refused");
    endtask
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        boot(1'b0, 16'h5a3c);
        chk(vendor_code, fsiw_pkg::VENDOR_CODE, "vendor");
        chk(revision_number, fsiw_pkg::REVISION_DEFAULT, "revision");
        chk(mode_monitor, fsiw_pkg::MODE_PROFILE, "start mode");
        chk(alias_monitor, 16'h1234, "alias monitor");
        acc(1'b0, fsiw_pkg::ALIAS_OFFSET, 16'h1234);
        acc(1'b0, fsiw_pkg::IDENT_OFFSET, 16'h5a3c);
        acc(1'b1, fsiw_pkg::ALIAS_OFFSET, 16'h0001);
        acc(1'b1, fsiw_pkg::IDENT_OFFSET, 16'h0001);
        acc(1'b1, 16'h0200, 16'h0000);
        acc(1'b0, 16'h0200, fsiw_pkg::UNMAPPED_READ);
        ident_request = 1'b1;
        step(1);
        ident_request = 1'b0;
        chk(al_status_code, 16'h5a3c, "status code");
        $display("test eeprom_alias done");
        boot(1'b1, 16'h0c81);
        chk(alias_monitor, 16'h00c5, "panel alias");
        acc(1'b0, fsiw_pkg::ALIAS_OFFSET, 16'h00c5);
        acc(1'b0, fsiw_pkg::IDENT_OFFSET, 16'h0c81);
        $display("test panel_alias done");
        u_mst.pulse(1'b1, 16'h0003);
        for (int i = 0; i < 6; i++) begin
            u_mst.pulse(1'b0, 16'h0003);
            step(8);
            chk(fieldbus_timeout_fault, 1'b0, "early fault");
        end
        u_mst.pulse(1'b0, 16'h0003);
        waited = 1;
        while (fieldbus_timeout_fault !== 1'b1 && waited < 40) begin
            step(1);
            waited++;
        end
        chk(waited >= 12 && waited <= 17, 1'b1, "expiry time");
        if (waited >= 40)
            wrap_up();
        u_mst.pulse(1'b0, 16'h0003);
        step(3);
        chk(fieldbus_timeout_fault, 1'b1, "latched fault");
        fault_clear = 1'b1;
        step(1);
        fault_clear = 1'b0;
        step(1);
        chk(fieldbus_timeout_fault, 1'b0, "cleared fault");
        u_mst.pulse(1'b1, 16'h0000);
        step(60);
        chk(fieldbus_timeout_fault, 1'b0, "no watchdog");
        $display("test watchdog done");
        mode_req(4'b1100, 8'h00, fsiw_pkg::MODE_BYPASS, 1'b0);
        mode_req(4'b0010, 8'h02, fsiw_pkg::MODE_PROFILE, 1'b0);
        mode_req(4'b0010, 8'h07, fsiw_pkg::MODE_BYPASS, 1'b0);
        mode_req(4'b1000, 8'h07, fsiw_pkg::MODE_PROFILE, 1'b0);
        {rx_1600_assigned, tx_1a00_assigned} = 2'b00;
        mode_req(4'b0001, 8'h07, fsiw_pkg::MODE_BYPASS, 1'b0);
        mode_req(4'b0010, 8'h02, fsiw_pkg::MODE_BYPASS, 1'b1);
        mode_req(4'b1000, 8'h07, fsiw_pkg::MODE_BYPASS, 1'b1);
        {rx_1600_assigned, tx_1a00_assigned} = 2'b11;
        mode_req(4'b0001, 8'h07, fsiw_pkg::MODE_PROFILE, 1'b0);
        $display("test mode done");
        {product_wr, revision_wr} = 2'b11;
        step(1);
        {product_wr, revision_wr} = 2'b00;
        chk(product_code, 32'h0000_4d21, "product");
        chk(revision_number, 16'h0007, "revision");
        $display("test identity done");
        wrap_up();
    end
endmodule
